// ==== hdl/eir_consts.svh ====
// Register indices, field positions and reset values of the external request block
`ifndef EIR_CONSTS_SVH
`define EIR_CONSTS_SVH

// Register indices; the APB byte address is four times the index
`define EIR_IDX_FLAGS 6'h38
`define EIR_IDX_ENABLES 6'h39
`define EIR_IDX_SENSE 6'h3a
`define EIR_IDX_CAUSE 6'h34
`define EIR_IDX_GLOBAL 6'h3f

// Reset values
`define EIR_RST_FLAGS 4'h0
`define EIR_RST_ENABLES 8'h00
`define EIR_RST_SENSE 8'h00
`define EIR_RST_GLOBAL 1'h0

// Field positions
`define EIR_BIT_POWER_ON 0
`define EIR_BIT_PIN_RESET 1
`define EIR_BIT_GLOBAL 0
`define EIR_FIRST_EDGE_LINE 4
`define EIR_LINE_COUNT 8

`endif

// ==== hdl/eir_pkg.sv ====
// Types shared by the external request block
package eir_pkg;

   typedef enum logic [1:0]
   {
      EIR_SENSE_LOW = 2'h0,
      EIR_SENSE_RSVD = 2'h1,
      EIR_SENSE_FALL = 2'h2,
      EIR_SENSE_RISE = 2'h3
   } eir_sense_e;

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } eir_apb_req_s;

   typedef struct packed
   {
      logic powerOn;
      logic pinReset;
      logic watchdog;
   } eir_reset_cause_s;

endpackage : eir_pkg

// ==== hdl/eir_sense_line.sv ====
// One request pin: synchroniser, edge detector and low-level sense
module eir_sense_line
   import eir_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pin and mode
   input wire logic requestPin,
   input eir_sense_e senseMode,
   // Detected conditions
   output logic levelLow,
   output logic edgeHit
);

   logic syncFirst_reg;
   logic syncSecond_reg;
   logic prevSample_reg;
   wire fallSeen;
   wire riseSeen;

   // Idle high so release from reset raises no false edge
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         syncFirst_reg <= 1'b1;
         syncSecond_reg <= 1'b1;
         prevSample_reg <= 1'b1;
      end
      else
      begin
         syncFirst_reg <= requestPin;
         syncSecond_reg <= syncFirst_reg;
         prevSample_reg <= syncSecond_reg;
      end
   end

   assign fallSeen = prevSample_reg & ~syncSecond_reg;
   assign riseSeen = ~prevSample_reg & syncSecond_reg;
   assign levelLow = ~syncSecond_reg;
   assign edgeHit = (senseMode == EIR_SENSE_FALL) ? fallSeen :
                    (senseMode == EIR_SENSE_RISE) ? riseSeen : 1'b0;

endmodule : eir_sense_line

// ==== hdl/eir_top.sv ====
// External request lines, request masking and the reset cause record, on APB
`include "eir_consts.svh"

// What this block does
// - An external pin reset sets the pin flag; watchdog reset leaves it alone.
// - Power-on reset sets the power-on flag; other resets keep it.
// - Upper six bits of the reset cause register read as zero.
// - Accepting an interrupt clears the global enable.
// - Return from handler sets the global enable; software may set it too.
// - Vectoring to a handler clears that source's pending flag.
// - Writing one to an edge flag clears it; zero leaves it. Reset cause flags clear on a written zero.
// - A flag is set and held even while its enable is zero.
// - Flags set while globally disabled stay pending, served by priority.
// - A level-sensed request sets no flag, pending only while low.
// - The status register is neither saved nor restored on entry or return.
// - Each enable bit, reset zero, gates its line only with global enable.
// - Pin activity requests even when the pin is driven as an output.
// - Lines 3 to 0 are low-level only, requesting while held low.
// - Edge flags 7 to 4 are set by a triggering edge.
// - Edge flags are held zero while their line is in low-level mode.
// - Flag register bits 3 to 0 read as zero.
// - Sense field per line 7..4: low, reserved, falling, rising.
// - Pins are sampled before edge detection; wider than one clock is caught.
module eir_top
   import eir_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input eir_apb_req_s apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External request pins
   input wire logic [7:0] requestPins,
   // Reset generator causes, same clock, sampled on every rising edge
   input eir_reset_cause_s resetCause,
   // Core vectoring
   input wire logic irqTake,
   input wire logic returnFromHandler,
   output logic irqRequest,
   output logic [2:0] irqLine,
   output logic globalEnable
);

   logic [3:0] edgeFlags_reg;
   logic [3:0] edgeFlags_next;
   logic [7:0] enables_reg;
   logic [7:0] senseCtrl_reg;
   logic globalEnable_reg;
   logic globalEnable_next;
   logic powerOnFlag_reg;
   logic pinResetFlag_reg;
   logic [31:0] prdata_reg;
   logic pslverr_reg;
   logic [2:0] firstLine;
   logic [7:0] levelLow;
   logic [7:0] edgeHit;
   logic [7:0] pending;

   wire setupPhase;
   wire writeAccess;
   wire wordAligned;
   wire [5:0] regIndex;
   wire hitFlags;
   wire hitEnables;
   wire hitSense;
   wire hitCause;
   wire hitGlobal;
   wire mapped;
   wire wrFlags;
   wire wrEnables;
   wire wrSense;
   wire wrCause;
   wire wrGlobal;
   wire [7:0] wrByte;
   wire [7:0] enabledReq;
   wire takeValid;
   wire [31:0] readMux;

   // APB decode; the slave always answers in the first access cycle
   assign setupPhase = apbReq.psel & ~apbReq.penable;
   assign writeAccess = apbReq.psel & apbReq.penable & apbReq.pwrite;
   assign wordAligned = (apbReq.paddr[1:0] == 2'h0);
   assign regIndex = apbReq.paddr[7:2];
   assign hitFlags = wordAligned & (regIndex == `EIR_IDX_FLAGS);
   assign hitEnables = wordAligned & (regIndex == `EIR_IDX_ENABLES);
   assign hitSense = wordAligned & (regIndex == `EIR_IDX_SENSE);
   assign hitCause = wordAligned & (regIndex == `EIR_IDX_CAUSE);
   assign hitGlobal = wordAligned & (regIndex == `EIR_IDX_GLOBAL);
   assign mapped = hitFlags | hitEnables | hitSense | hitCause | hitGlobal;
   assign wrFlags = writeAccess & hitFlags;
   assign wrEnables = writeAccess & hitEnables;
   assign wrSense = writeAccess & hitSense;
   assign wrCause = writeAccess & hitCause;
   assign wrGlobal = writeAccess & hitGlobal;
   assign wrByte = apbReq.pwdata[7:0];

   // Per-line sensing; lines 3..0 have no mode field and stay low-level
   genvar g;
   generate
      for (g = 0; g < `EIR_LINE_COUNT; g++)
      begin : gLine
         eir_sense_e lineMode;
         if (g >= `EIR_FIRST_EDGE_LINE)
         begin : gCfg
            assign lineMode = eir_sense_e'(senseCtrl_reg[2*(g-4) +: 2]);
         end
         else
         begin : gFix
            assign lineMode = EIR_SENSE_LOW;
         end
         // Pins are read whatever their port direction
         eir_sense_line uSense
         (
            .clk(clk),
            .nrst(nrst),
            .requestPin(requestPins[g]),
            .senseMode(lineMode),
            .levelLow(levelLow[g]),
            .edgeHit(edgeHit[g])
         );
      end
   endgenerate

   // Only meaningful for lines 7..4, which own a mode field
   function automatic logic gLineModeIsLow(input int idx);
      logic [1:0] fld;
      fld = senseCtrl_reg[2*(idx-4) +: 2];
      return (fld == EIR_SENSE_LOW);
   endfunction : gLineModeIsLow

   // Pending conditions before any masking
   always_comb
   begin
      pending = 8'h00;
      for (int i = 0; i < `EIR_LINE_COUNT; i++)
      begin
         if (i < `EIR_FIRST_EDGE_LINE)
            pending[i] = levelLow[i];
         else if (gLineModeIsLow(i))
            pending[i] = levelLow[i];
         else
            pending[i] = edgeFlags_reg[i-4];
      end
   end

   assign enabledReq = pending & enables_reg;
   assign irqRequest = globalEnable_reg & (|enabledReq);

   // Lowest line first
   always_comb
   begin
      firstLine = 3'h0;
      for (int i = `EIR_LINE_COUNT - 1; i >= 0; i--)
      begin
         if (enabledReq[i])
            firstLine = i[2:0];
      end
   end
   assign irqLine = firstLine;
   assign takeValid = irqTake & irqRequest;

   // Edge flags: the set wins over write and vectoring clears in the same cycle; low-level mode forces zero over the set
   always_comb
   begin
      edgeFlags_next = edgeFlags_reg;
      for (int k = 0; k < 4; k++)
      begin
         if (wrFlags & wrByte[k+4])
            edgeFlags_next[k] = 1'b0;
         if (takeValid & (irqLine == 3'(k + 4)))
            edgeFlags_next[k] = 1'b0;
         if (edgeHit[k+4])
            edgeFlags_next[k] = 1'b1;
         if (gLineModeIsLow(k + 4))
            edgeFlags_next[k] = 1'b0;
      end
   end

   // Status register stays with software across entry and return
   always_comb
   begin
      globalEnable_next = globalEnable_reg;
      if (takeValid)
         globalEnable_next = 1'b0;
      else if (returnFromHandler)
         globalEnable_next = 1'b1;
      else if (wrGlobal)
         globalEnable_next = wrByte[`EIR_BIT_GLOBAL];
   end
   assign globalEnable = globalEnable_reg;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         edgeFlags_reg <= `EIR_RST_FLAGS;
         enables_reg <= `EIR_RST_ENABLES;
         senseCtrl_reg <= `EIR_RST_SENSE;
         globalEnable_reg <= `EIR_RST_GLOBAL;
      end
      else
      begin
         edgeFlags_reg <= edgeFlags_next;
         globalEnable_reg <= globalEnable_next;
         if (wrEnables)
            enables_reg <= wrByte;
         if (wrSense)
            senseCtrl_reg <= wrByte;
      end
   end

   // Reset cause record survives the chip reset, so nrst does not touch it
   always_ff @(posedge clk)
   begin
      if (resetCause.powerOn)
      begin
         powerOnFlag_reg <= 1'b1;
         pinResetFlag_reg <= 1'b0;
      end
      else if (resetCause.pinReset)
         pinResetFlag_reg <= 1'b1;
      else if (wrCause)
      begin
         // Software clears a flag by writing zero to it
         powerOnFlag_reg <= powerOnFlag_reg & wrByte[`EIR_BIT_POWER_ON];
         pinResetFlag_reg <= pinResetFlag_reg & wrByte[`EIR_BIT_PIN_RESET];
      end
   end

   // Read data is captured in the setup cycle so it is steady when pready is high
   assign readMux =
      hitFlags ? {24'h0, edgeFlags_reg, 4'h0} :
      hitEnables ? {24'h0, enables_reg} :
      hitSense ? {24'h0, senseCtrl_reg} :
      hitCause ? {30'h0, pinResetFlag_reg, powerOnFlag_reg} :
      hitGlobal ? {31'h0, globalEnable_reg} : 32'h0;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
      end
      else if (setupPhase)
      begin
         prdata_reg <= apbReq.pwrite ? 32'h0 : readMux;
         pslverr_reg <= ~mapped;
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign pready = 1'b1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence seqCauseRead;
      setupPhase && hitCause && !apbReq.pwrite;
   endsequence

   a_cause_upper_zero: assert property (seqCauseRead |=> prdata[7:2] == 6'h0)
      else $error("Reset cause upper bits not zero");

   a_por_sets_flag: assert property (resetCause.powerOn |=> powerOnFlag_reg)
      else $error("Power-on flag not set");

   a_pin_sets_flag: assert property
      (resetCause.pinReset && !resetCause.powerOn |=> pinResetFlag_reg)
      else $error("Pin reset flag not set");

   a_wdog_keeps_flags: assert property
      (resetCause.watchdog && !resetCause.powerOn && !resetCause.pinReset && !wrCause
       |=> $stable(pinResetFlag_reg) && $stable(powerOnFlag_reg))
      else $error("Watchdog reset changed a cause flag");

   a_take_clears_enable: assert property (irqTake && irqRequest |=> !globalEnable)
      else $error("Global enable not cleared on accept");

   a_return_sets_enable: assert property
      (returnFromHandler && !(irqTake && irqRequest) |=> globalEnable ##0 irqRequest == |enabledReq)
      else $error("Global enable not set on return");

   sequence seqTakeEdge;
      irqTake && irqRequest && irqLine >= 3'h4 && !edgeHit[irqLine];
   endsequence

   a_vector_clears_flag: assert property
      (seqTakeEdge |=> !edgeFlags_reg[$past(irqLine[1:0])])
      else $error("Vectored flag not cleared");

   a_write_one_clears: assert property
      (wrFlags && wrByte[5] && !edgeHit[5] |=> !edgeFlags_reg[1])
      else $error("Write of one did not clear flag");

   a_edge_sets_flag: assert property
      (edgeHit[6] && !gLineModeIsLow(6) && !wrSense |=> edgeFlags_reg[2])
      else $error("Edge did not set flag");

   a_level_flag_zero: assert property (senseCtrl_reg[7:6] == 2'h0 |=> !edgeFlags_reg[3])
      else $error("Flag set in level mode");

   a_low_line_level: assert property
      (irqRequest && irqLine < 3'h4 |-> levelLow[irqLine] && enables_reg[irqLine])
      else $error("Low line request without low level");

   a_priority_lowest: assert property
      (irqRequest && irqLine != 3'h0 |-> (enabledReq & ((8'h1 << irqLine) - 8'h1)) == 8'h0)
      else $error("Lower line was not served first");

   a_flag_low_zero: assert property
      (setupPhase && hitFlags && !apbReq.pwrite |=> prdata[3:0] == 4'h0)
      else $error("Flag register low bits not zero");

   a_rsvd_no_flag: assert property
      (senseCtrl_reg[5:4] == 2'h1 && !edgeFlags_reg[2] |=> !edgeFlags_reg[2])
      else $error("Reserved sense mode set a flag");

   a_enable_write: assert property
      (wrEnables |=> enables_reg == $past(wrByte))
      else $error("Enable register write lost");

   a_sense_write: assert property
      (wrSense |=> senseCtrl_reg == $past(wrByte))
      else $error("Sense register write lost");

   a_global_write: assert property
      (wrGlobal && !takeValid && !returnFromHandler |=> globalEnable == $past(wrByte[0]))
      else $error("Global enable write lost");

   // Pin held three clocks, so both sampling stages and the edge stage see it
   sequence seqRiseLine4;
      $rose(requestPins[4]) && senseCtrl_reg[1:0] == 2'h3
      ##1 (requestPins[4] && senseCtrl_reg[1:0] == 2'h3) [*2];
   endsequence

   a_sync_rise_flag: assert property (seqRiseLine4 |=> edgeFlags_reg[0])
      else $error("Rising pulse on a sampled pin was missed");

endmodule : eir_top

// ==== tb/eir_core_model.sv ====
// Behavioural core: takes offered requests and executes returns on command
module eir_core_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Block side
   input wire logic irqRequest,
   input wire logic [2:0] irqLine,
   output logic irqTake,
   output logic returnFromHandler,
   // Bench side
   input wire logic autoTake,
   input wire logic retReq,
   output logic [2:0] lastLine
);
   timeunit 1ns;
   timeprecision 1ps;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         irqTake <= 1'b0;
         returnFromHandler <= 1'b0;
         lastLine <= 3'h0;
      end
      else
      begin
         // Pulse, so one offered request is taken once
         irqTake <= autoTake && irqRequest && !irqTake;
         returnFromHandler <= retReq;
         if (irqTake && irqRequest)
            lastLine <= irqLine;
      end
   end
endmodule : eir_core_model

// ==== tb/eir_top_tb.sv ====
// Self-checking bench of the external request block
`include "eir_consts.svh"
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin errCount++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module eir_top_tb
   import eir_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, nrst, pready, pslverr, irqTake, returnFromHandler;
   logic irqRequest, globalEnable, autoTake, retReq, err;
   logic [2:0] irqLine, lastLine;
   logic [7:0] pins, rd, sv;
   logic [31:0] prdata;
   eir_apb_req_s req;
   eir_reset_cause_s cause;
   int errCount, nChecks, seed, w;

   eir_top eir_top_inst (.clk(clk), .nrst(nrst), .apbReq(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .requestPins(pins), .resetCause(cause),
      .irqTake(irqTake), .returnFromHandler(returnFromHandler), .irqRequest(irqRequest),
      .irqLine(irqLine), .globalEnable(globalEnable));
   eir_core_model eir_core_model_inst (.clk(clk), .nrst(nrst), .irqRequest(irqRequest),
      .irqLine(irqLine), .irqTake(irqTake), .returnFromHandler(returnFromHandler),
      .autoTake(autoTake), .retReq(retReq), .lastLine(lastLine));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
      @(posedge clk);
      req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {24'h0, wd}};
      @(posedge clk);
      req.penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata[7:0];
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic setPins(input logic [7:0] v);
      @(posedge clk);
      pins <= v;
   endtask : setPins

   task automatic causeStep(input logic [2:0] c, input logic [7:0] e);
      @(posedge clk);
      cause <= c;
      @(posedge clk);
      cause <= 3'h0;
      apb(1'b0, `EIR_IDX_CAUSE, 8'h00);
      `CHK(rd, e)
   endtask : causeStep

   task automatic take();
      @(posedge clk);
      autoTake <= 1'b1;
      tick(4);
      autoTake <= 1'b0;
   endtask : take

   function automatic logic [7:0] expFlag(input eir_sense_e m, input int ln);
      return (m == EIR_SENSE_FALL || m == EIR_SENSE_RISE) ? 8'h01 << ln : 8'h00;
   endfunction : expFlag

   task automatic stopTest();
      $display("Checks %0d, mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stopTest

   // Generous bound; the sequence needs well under a thousand cycles
   initial
   begin
      #200us;
      errCount++;
      stopTest();
   end

   initial
   begin
      seed = 62715;
      nrst = 1'b0;
      req = '0;
      cause = 3'b100;
      pins = 8'hff;
      autoTake = 1'b0;
      retReq = 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      cause <= 3'h0;
      apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
      `CHK(rd, 8'h00)
      apb(1'b0, `EIR_IDX_ENABLES, 8'h00);
      `CHK(rd, 8'h00)
      apb(1'b0, `EIR_IDX_SENSE, 8'h00);
      `CHK(rd, 8'h00)
      apb(1'b0, `EIR_IDX_CAUSE, 8'h00);
      `CHK(rd, 8'h01)
      causeStep(3'b010, 8'h03);
      causeStep(3'b001, 8'h03);
      apb(1'b1, `EIR_IDX_CAUSE, 8'h00);
      causeStep(3'b001, 8'h00);
      causeStep(3'b010, 8'h02);
      causeStep(3'b100, 8'h01);
      apb(1'b0, 6'h00, 8'h00);
      `CHK({err, rd}, 9'h100)
      repeat (4)
      begin
         sv = 8'($random(seed));
         apb(1'b1, `EIR_IDX_ENABLES, sv);
         apb(1'b0, `EIR_IDX_ENABLES, 8'h00);
         `CHK(rd, sv)
      end
      apb(1'b1, `EIR_IDX_ENABLES, 8'h00);
      for (int ln = 4; ln < 8; ln++)
         for (int m = 0; m < 4; m++)
         begin
            sv = 8'(m) << (2 * (ln - 4));
            apb(1'b1, `EIR_IDX_SENSE, sv);
            apb(1'b0, `EIR_IDX_SENSE, 8'h00);
            `CHK(rd, sv)
            w = 2 + ($random(seed) & 3);
            setPins(~(8'h01 << ln));
            tick(w);
            setPins(8'hff);
            tick(4);
            apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
            `CHK(rd, expFlag(eir_sense_e'(m), ln))
            `CHK(irqRequest, 1'b0)
            apb(1'b1, `EIR_IDX_FLAGS, 8'h00);
            apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
            `CHK(rd, expFlag(eir_sense_e'(m), ln))
            apb(1'b1, `EIR_IDX_FLAGS, 8'hf0);
            apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
            `CHK(rd, 8'h00)
         end
      // A flag left from edge mode is dropped once the line turns to level
      apb(1'b1, `EIR_IDX_SENSE, 8'h80);
      setPins(8'h7f);
      tick(2);
      setPins(8'hff);
      tick(4);
      apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
      `CHK(rd, expFlag(EIR_SENSE_FALL, 7))
      apb(1'b1, `EIR_IDX_SENSE, 8'h00);
      apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
      `CHK(rd, 8'h00)
      apb(1'b1, `EIR_IDX_ENABLES, 8'hff);
      apb(1'b1, `EIR_IDX_SENSE, 8'hff);
      setPins(8'h9f);
      tick(2);
      setPins(8'hff);
      tick(4);
      `CHK(irqRequest, 1'b0)
      apb(1'b1, `EIR_IDX_GLOBAL, 8'h01);
      tick(1);
      `CHK({irqRequest, irqLine}, 4'hd)
      take();
      `CHK(lastLine, 3'h5)
      `CHK(globalEnable, 1'b0)
      apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
      `CHK(rd, 8'h40)
      @(posedge clk);
      retReq <= 1'b1;
      @(posedge clk);
      retReq <= 1'b0;
      tick(2);
      `CHK(globalEnable, 1'b1)
      take();
      `CHK(lastLine, 3'h6)
      apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
      `CHK(rd, 8'h00)
      apb(1'b1, `EIR_IDX_SENSE, 8'h00);
      // Level sources stay low until taken
      setPins(8'hfa);
      tick(3);
      apb(1'b1, `EIR_IDX_GLOBAL, 8'h01);
      tick(1);
      `CHK({irqRequest, irqLine}, 4'h8)
      take();
      `CHK(lastLine, 3'h0)
      `CHK(globalEnable, 1'b0)
      apb(1'b0, `EIR_IDX_FLAGS, 8'h00);
      `CHK(rd, 8'h00)
      setPins(8'hff);
      tick(3);
      apb(1'b1, `EIR_IDX_GLOBAL, 8'h01);
      tick(1);
      `CHK(irqRequest, 1'b0)
      apb(1'b1, `EIR_IDX_ENABLES, 8'h00);
      setPins(8'hfd);
      tick(3);
      `CHK(irqRequest, 1'b0)
      apb(1'b1, `EIR_IDX_ENABLES, 8'h02);
      tick(1);
      `CHK({irqRequest, irqLine}, 4'h9)
      setPins(8'hff);
      tick(2);
      // Chip reset in mid-run must leave the reset cause record alone
      @(posedge clk);
      nrst <= 1'b0;
      tick(3);
      nrst <= 1'b1;
      apb(1'b0, `EIR_IDX_CAUSE, 8'h00);
      `CHK(rd, 8'h01)
      apb(1'b0, `EIR_IDX_ENABLES, 8'h00);
      `CHK({rd, globalEnable}, 9'h000)
      stopTest();
   end
endmodule : eir_top_tb
